/* design/pmcc_defines.svh */
// offsets, field positions, reset values and timing counts of the power mode clock controller
`ifndef PMCC_DEFINES_SVH
`define PMCC_DEFINES_SVH
// register indices; byte address is four times the index
`define PMCC_IDX_CLK_SRC 6'h00
`define PMCC_IDX_GAIN 6'h01
`define PMCC_IDX_TRIM 6'h02
`define PMCC_IDX_LVL 6'h03
`define PMCC_IDX_WAKE 6'h07
`define PMCC_IDX_CPU_DIV 6'h2e
`define PMCC_IDX_STATUS 6'h30
// reset values
`define PMCC_RST_CLK_SRC 2'h0
`define PMCC_RST_GAIN 3'h0
`define PMCC_RST_TRIM 6'h14
`define PMCC_RST_LVL 2'h2
`define PMCC_RST_WAKE 8'h00
`define PMCC_RST_CPU_DIV 6'h00
// status register field positions
`define PMCC_ST_MODE_LSB 0
`define PMCC_ST_LVD_LOW 3
`define PMCC_ST_LVD_EN 4
`define PMCC_ST_GAIN_BAD 5
`define PMCC_ST_WAKE_IRQ 6
// clock source codes
`define PMCC_SRC_INT 2'h0
`define PMCC_SRC_EXT 2'h1
`define PMCC_SRC_RC 2'h2
// timing
`define PMCC_CLK_PERIOD_NS 20
`define PMCC_LVD_FILT_NS 5000
`define PMCC_STARTUP_CYC 4096
`endif

/* design/pmcc_pkg.sv */
// types of the power mode clock controller
package pmcc_pkg;
  typedef enum logic [2:0] {
    PMCC_FIXED = 3'b000,
    PMCC_PRESC = 3'b001,
    PMCC_RUN = 3'b010,
    PMCC_WAIT = 3'b011,
    PMCC_HALT = 3'b100,
    PMCC_LVDRST = 3'b101,
    PMCC_RESTART = 3'b110
  } pmcc_mode_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pmcc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmcc_apb_rsp_t;
endpackage : pmcc_pkg

/* design/pmcc_top.sv */
// power mode, start-up delay, supply drop reset and cpu clock divider controller
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "pmcc_defines.svh"

module pmcc_top
  import pmcc_pkg::*;
#(
  parameter int STARTUP_CYC = `PMCC_STARTUP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic pin_resetn_i,
  input wire logic wdg_reset_i,
  input wire logic supply_low_i,
  input wire logic wait_instr_i,
  input wire logic halt_instr_i,
  input wire logic watchdog_en_i,
  input wire logic irq_i,
  input wire logic nmi_i,
  input wire logic port_irq_i,
  input wire logic port_irq_en_i,
  input wire logic [1:0] opt_clk_src_i,
  input wire logic [2:0] opt_gain_i,
  input wire logic [5:0] opt_trim_i,
  input wire logic [1:0] opt_lvl_i,
  input wire logic [7:0] opt_wake_i,
  input wire pmcc_apb_req_t apb_req_i,
  output pmcc_apb_rsp_t apb_rsp_o,
  output logic cpu_reset_o,
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic osc_on_o,
  output logic [1:0] clk_src_o,
  output logic [3:0] gain_stages_o,
  output logic [5:0] osc_trim_o,
  output logic [1:0] supply_drop_level_o,
  output logic serve_irq_o,
  output pmcc_mode_t mode_o
);
  localparam int LVD_FILT_CYC =
    (`PMCC_LVD_FILT_NS + `PMCC_CLK_PERIOD_NS - 1) / `PMCC_CLK_PERIOD_NS;
  typedef struct packed {
    pmcc_mode_t st;
    logic [12:0] cnt;
    logic [7:0] pre;
    logic [7:0] flt_cnt;
    logic lvd_low;
    logic opt_ld;
    logic [1:0] clk_src_field;
    logic [2:0] gain_stage_field;
    logic [5:0] osc_trim_field;
    logic [1:0] supply_drop_level_field;
    logic [7:0] startup_delay_prescaler;
    logic [5:0] cpu_divider_field;
    logic [2:0] div_exp;
    logic [5:0] div_cnt;
    logic wake_irq;
    logic cpu_rst;
    logic cpu_clk_en;
    logic osc_on;
    logic [1:0] clk_src;
    logic [3:0] gain_stages;
    logic serve_irq;
    logic [7:0] prdata;
    logic pready;
    logic pslverr;
  } pmcc_regs_t;
  pmcc_regs_t q;
  pmcc_regs_t d;
  ////////////////////////////////////////////////////////////////////////////
  // decoders
  // divider field to power of two
  function automatic logic [2:0] div_decode(input logic [5:0] f);
    logic [2:0] e;
    e = 3'h6;
    unique case (f)
      6'h00: e = 3'h0;
      6'h01: e = 3'h1;
      6'h02: e = 3'h2;
      6'h04: e = 3'h3;
      6'h08: e = 3'h4;
      6'h10: e = 3'h5;
      default: e = 3'h6;
    endcase
    return e;
  endfunction : div_decode
  // gain code to stage count
  function automatic logic [3:0] gain_decode(input logic [2:0] g);
    logic [3:0] n;
    n = 4'h0;
    unique case (g)
      3'h1: n = 4'h1;
      3'h3: n = 4'h3;
      3'h5: n = 4'h6;
      3'h7: n = 4'h8;
      default: n = 4'h0;
    endcase
    return n;
  endfunction : gain_decode
  logic gain_bad;
  logic lvd_en;
  logic lvd_active;
  logic soft_rst;
  logic tick;
  logic [5:0] div_mask;
  logic apb_setup;
  logic apb_wr;
  logic [5:0] idx;
  logic addr_ok;
  logic [7:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    // illegal gain codes are flagged and drive no stage
    gain_bad = (q.gain_stage_field == 3'h2) || (q.gain_stage_field == 3'h4) ||
               (q.gain_stage_field == 3'h6);
    lvd_en = (q.supply_drop_level_field != 2'h0);
    lvd_active = lvd_en && (q.st != PMCC_HALT);
    soft_rst = 1'b0;
    div_mask = 6'((7'h01 << q.div_exp) - 7'h01);
    tick = (q.div_cnt == div_mask);
    apb_setup = apb_req_i.psel && !apb_req_i.penable;
    apb_wr = apb_req_i.psel && apb_req_i.penable && q.pready && apb_req_i.pwrite;
    idx = apb_req_i.paddr[7:2];
    addr_ok = (apb_req_i.paddr[1:0] == 2'h0);
    rd_val = 8'h00;
    // option bytes are sampled once after a power-on or pin reset
    if (!q.opt_ld) begin
      d.opt_ld = 1'b1;
      d.clk_src_field = opt_clk_src_i;
      d.gain_stage_field = opt_gain_i;
      d.osc_trim_field = opt_trim_i;
      d.supply_drop_level_field = opt_lvl_i;
      d.startup_delay_prescaler = opt_wake_i;
    end
    // spike filter on the comparator, 5 us of steady input flips it
    if (!lvd_active) begin
      d.lvd_low = 1'b0;
      d.flt_cnt = 8'h00;
    end else if (supply_low_i == q.lvd_low) begin
      d.flt_cnt = 8'h00;
    end else if (q.flt_cnt == 8'(LVD_FILT_CYC - 1)) begin
      d.lvd_low = supply_low_i;
      d.flt_cnt = 8'h00;
    end else begin
      d.flt_cnt = q.flt_cnt + 8'h01;
    end
    // power mode sequencer
    unique case (q.st)
      PMCC_FIXED: begin
        d.cnt = q.cnt + 13'h0001;
        if (q.cnt == 13'(STARTUP_CYC - 1)) begin
          d.cnt = 13'h0000;
          d.pre = 8'h00;
          if (q.clk_src_field == `PMCC_SRC_INT) begin
            d.st = PMCC_RUN;
          end else begin
            d.st = PMCC_PRESC;
          end
        end
      end
      PMCC_PRESC: begin
        d.cnt = q.cnt + 13'h0001;
        if (q.cnt == 13'(STARTUP_CYC - 1)) begin
          d.cnt = 13'h0000;
          d.pre = q.pre + 8'h01;
          if (q.pre == q.startup_delay_prescaler) begin
            d.st = PMCC_RUN;
          end
        end
      end
      PMCC_RUN: begin
        if (wait_instr_i) begin
          d.st = PMCC_WAIT;
        end else if (halt_instr_i && !watchdog_en_i) begin
          d.st = PMCC_HALT;
        end
      end
      PMCC_WAIT: begin
        if (irq_i || nmi_i || (port_irq_i && port_irq_en_i)) begin
          d.st = PMCC_RUN;
        end
      end
      PMCC_HALT: begin
        if (nmi_i || (port_irq_i && port_irq_en_i)) begin
          d.st = PMCC_FIXED;
          d.cnt = 13'h0000;
          d.wake_irq = 1'b1;
        end
      end
      PMCC_LVDRST: begin
        if (!q.lvd_low) begin
          d.st = PMCC_RUN;
        end
      end
      PMCC_RESTART: begin
        d.st = PMCC_RUN;
      end
      default: begin
        d.st = PMCC_FIXED;
        d.cnt = 13'h0000;
      end
    endcase
    // interrupt that woke the part is handed over once running
    d.serve_irq = 1'b0;
    if (q.wake_irq && d.st == PMCC_RUN) begin
      d.serve_irq = 1'b1;
      d.wake_irq = 1'b0;
    end
    // apb register write, only the divider field is writable
    if (apb_wr && addr_ok && idx == `PMCC_IDX_CPU_DIV) begin
      d.cpu_divider_field = apb_req_i.pwdata[5:0];
    end
    // internal resets: drop monitor first, then watchdog
    if (q.lvd_low) begin
      d.st = PMCC_LVDRST;
      soft_rst = 1'b1;
    end else if (wdg_reset_i) begin
      d.st = PMCC_RESTART;
      soft_rst = 1'b1;
    end
    if (!pin_resetn_i) begin
      d.st = PMCC_FIXED;
      d.cnt = 13'h0000;
      d.opt_ld = 1'b0;
      soft_rst = 1'b1;
    end
    if (soft_rst) begin
      // filter state survives, option fields too except after a pin reset; divider field, divider state, wake and serve flags are cleared
      d.cpu_divider_field = `PMCC_RST_CPU_DIV;
      d.wake_irq = 1'b0;
      d.serve_irq = 1'b0;
      d.div_exp = 3'h0;
      d.div_cnt = 6'h00;
    end else if (tick) begin
      // new divider ratio is taken only at the end of a divided period
      d.div_cnt = 6'h00;
      d.div_exp = div_decode(q.cpu_divider_field);
    end else begin
      d.div_cnt = q.div_cnt + 6'h01;
    end
    // clock outputs follow the next mode
    d.cpu_clk_en = tick && !soft_rst && (d.st == PMCC_RUN);
    d.osc_on = (d.st != PMCC_HALT);
    d.cpu_rst = (d.st == PMCC_FIXED) || (d.st == PMCC_PRESC) ||
                (d.st == PMCC_LVDRST) || (d.st == PMCC_RESTART);
    // internal clock until start-up is over
    if (d.st == PMCC_FIXED || d.st == PMCC_PRESC) begin
      d.clk_src = `PMCC_SRC_INT;
    end else if (q.clk_src_field[1]) begin
      d.clk_src = `PMCC_SRC_RC;
    end else begin
      d.clk_src = q.clk_src_field;
    end
    d.gain_stages = gain_decode(q.gain_stage_field);
    // apb read data and error, answered in the access phase
    unique case (idx)
      `PMCC_IDX_CLK_SRC: rd_val = {6'h00, q.clk_src_field};
      `PMCC_IDX_GAIN: rd_val = {5'h00, q.gain_stage_field};
      `PMCC_IDX_TRIM: rd_val = {2'h0, q.osc_trim_field};
      `PMCC_IDX_LVL: rd_val = {6'h00, q.supply_drop_level_field};
      `PMCC_IDX_WAKE: rd_val = q.startup_delay_prescaler;
      `PMCC_IDX_CPU_DIV: rd_val = {2'h0, q.cpu_divider_field};
      `PMCC_IDX_STATUS: begin
        rd_val[`PMCC_ST_MODE_LSB +: 3] = q.st;
        rd_val[`PMCC_ST_LVD_LOW] = q.lvd_low;
        rd_val[`PMCC_ST_LVD_EN] = lvd_en;
        rd_val[`PMCC_ST_GAIN_BAD] = gain_bad;
        rd_val[`PMCC_ST_WAKE_IRQ] = q.wake_irq;
      end
      default: rd_val = 8'h00;
    endcase
    d.pready = apb_setup;
    if (apb_setup) begin
      d.prdata = addr_ok ? rd_val : 8'h00;
      d.pslverr = !addr_ok ||
                  !(idx inside {`PMCC_IDX_CLK_SRC, `PMCC_IDX_GAIN, `PMCC_IDX_TRIM,
                                `PMCC_IDX_LVL, `PMCC_IDX_WAKE, `PMCC_IDX_CPU_DIV,
                                `PMCC_IDX_STATUS}) ||
                  (apb_req_i.pwrite && idx != `PMCC_IDX_CPU_DIV);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.st <= PMCC_FIXED;
      q.clk_src_field <= `PMCC_RST_CLK_SRC;
      q.gain_stage_field <= `PMCC_RST_GAIN;
      q.osc_trim_field <= `PMCC_RST_TRIM;
      q.supply_drop_level_field <= `PMCC_RST_LVL;
      q.startup_delay_prescaler <= `PMCC_RST_WAKE;
      q.cpu_divider_field <= `PMCC_RST_CPU_DIV;
      q.cpu_rst <= 1'b1;
      q.osc_on <= 1'b1;
    end else begin
      q <= d;
    end
  end
  // outputs straight from the state register
  assign apb_rsp_o.prdata = {24'h000000, q.prdata};
  assign apb_rsp_o.pready = q.pready;
  assign apb_rsp_o.pslverr = q.pslverr;
  assign cpu_reset_o = q.cpu_rst;
  assign cpu_clk_en_o = q.cpu_clk_en;
  assign periph_clk_en_o = q.osc_on;
  assign osc_on_o = q.osc_on;
  assign clk_src_o = q.clk_src;
  assign gain_stages_o = q.gain_stages;
  assign osc_trim_o = q.osc_trim_field;
  assign supply_drop_level_o = q.supply_drop_level_field;
  assign serve_irq_o = q.serve_irq;
  assign mode_o = q.st;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // consecutive cycles of low comparator input
  logic [8:0] low_run_q;
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || !supply_low_i) begin
      low_run_q <= 9'h000;
    end else if (low_run_q != 9'h1ff) begin
      low_run_q <= low_run_q + 9'h001;
    end
  end
  sequence s_no_reset;
    pin_resetn_i && !wdg_reset_i && !q.lvd_low;
  endsequence
  sequence s_halt_held;
    s_no_reset ##0 (q.st == PMCC_HALT);
  endsequence
  chk_lvd_filter_len: assert property (
    $rose(q.lvd_low) |-> low_run_q >= 9'(LVD_FILT_CYC))
    else $error("supply drop accepted before 5 us");
  chk_lvd_holds_reset: assert property (
    q.lvd_low && pin_resetn_i |=> q.cpu_rst && q.st == PMCC_LVDRST)
    else $error("supply drop did not hold cpu reset");
  chk_lvd_release_run: assert property (
    (q.st == PMCC_LVDRST && !q.lvd_low) ##0 s_no_reset |=> q.st == PMCC_RUN && !q.cpu_rst)
    else $error("supply drop reset not released");
  chk_halt_lvd_off: assert property (
    q.st == PMCC_HALT |=> !q.lvd_low)
    else $error("drop monitor active in halt");
  chk_halt_skipped: assert property (
    (q.st == PMCC_RUN && halt_instr_i && watchdog_en_i && !wait_instr_i) ##0 s_no_reset
    |=> q.st == PMCC_RUN)
    else $error("halt entered with watchdog enabled");
  chk_wait_cpu_stop: assert property (
    q.st == PMCC_WAIT |-> !q.cpu_clk_en && q.osc_on && q.osc_on == periph_clk_en_o)
    else $error("cpu clock running in wait");
  chk_halt_osc_off: assert property (
    s_halt_held |-> !q.osc_on ##1 (q.st != PMCC_HALT || !q.osc_on))
    else $error("oscillator on in halt");
  chk_masked_port: assert property (
    s_halt_held ##0 (!nmi_i && !(port_irq_i && port_irq_en_i)) |=> q.st == PMCC_HALT)
    else $error("halt left without enabled wake source");
  chk_fixed_delay: assert property (
    (q.st == PMCC_FIXED) ##0 s_no_reset ##1 (q.st inside {PMCC_RUN, PMCC_PRESC})
    |-> $past(q.cnt) == 13'(STARTUP_CYC - 1))
    else $error("start-up delay length wrong");
  chk_div_boundary: assert property (
    $changed(q.div_exp) |-> q.div_cnt == 6'h00 && $past(tick || soft_rst))
    else $error("divider changed inside a period");
endmodule : pmcc_top

/* tb/pmcc_cpu_model.sv */
// cpu core and interrupt source model facing the power mode clock controller
`timescale 1ns/1ns
module pmcc_cpu_model
  import pmcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire pmcc_mode_t mode_i,
  input wire logic serve_irq_i,
  input wire logic do_wait_i,
  input wire logic do_halt_i,
  input wire logic do_irq_i,
  input wire logic do_nmi_i,
  input wire logic do_port_i,
  output logic wait_instr_o,
  output logic halt_instr_o,
  output logic irq_o,
  output logic nmi_o,
  output logic port_irq_o
);
  logic wait_pend_q;
  logic halt_pend_q;
  ////////////////////////////////////////////////////////////////////////////////
  // instructions wait for the running state; irq stays up until running, nmi and port until served
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wait_pend_q <= 1'h0;
      halt_pend_q <= 1'h0;
      wait_instr_o <= 1'h0;
      halt_instr_o <= 1'h0;
      irq_o <= 1'h0;
      nmi_o <= 1'h0;
      port_irq_o <= 1'h0;
    end else begin
      wait_pend_q <= do_wait_i | (wait_pend_q & (mode_i != PMCC_RUN));
      halt_pend_q <= do_halt_i | (halt_pend_q & (mode_i != PMCC_RUN));
      wait_instr_o <= wait_pend_q & (mode_i == PMCC_RUN);
      halt_instr_o <= halt_pend_q & (mode_i == PMCC_RUN);
      irq_o <= do_irq_i | (irq_o & (mode_i != PMCC_RUN));
      nmi_o <= do_nmi_i | (nmi_o & !serve_irq_i);
      port_irq_o <= do_port_i | (port_irq_o & !serve_irq_i);
    end
  end
endmodule : pmcc_cpu_model

/* tb/pmcc_top_test.sv */
// self-checking bench of the power mode clock controller
`timescale 1ns/1ns
module pmcc_top_test;
  import pmcc_pkg::*;
  localparam int SCYC = 16;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic pin_rstn = 1'h1;
  logic wdg_rst = 1'h0;
  logic sup_low = 1'h0;
  logic wdg_en = 1'h0;
  logic port_en = 1'h0;
  logic do_wait = 1'h0;
  logic do_halt = 1'h0;
  logic do_irq = 1'h0;
  logic do_nmi = 1'h0;
  logic do_port = 1'h0;
  logic [1:0] o_src = 2'h1;  // driven external clock, so no gain
  logic [2:0] o_gain = 3'h0;
  logic [5:0] o_trim = 6'h14;  // nominal trim within the limit
  logic [1:0] o_lvl = 2'h1;
  logic [7:0] o_wake = 8'h01;
  pmcc_apb_req_t req = '0;
  pmcc_apb_rsp_t rsp;
  logic wi, hi, irq, nmi, pirq, cpu_rst, cen, pen, osc, serve, err, s;
  logic [1:0] src;
  logic [3:0] gst;
  logic [5:0] trim;
  logic [1:0] lvl;
  pmcc_mode_t mode;
  logic [31:0] rd;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] ra [0:5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'hb8};
  logic [7:0] rv [0:5] = '{8'h01, 8'h00, 8'h14, 8'h01, 8'h01, 8'h00};
  logic [5:0] dv [0:7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h03};
  logic [3:0] gx [0:7] = '{4'h0, 4'h1, 4'h0, 4'h3, 4'h0, 4'h6, 4'h0, 4'h8};

  pmcc_top #(.STARTUP_CYC(SCYC)) pmcc_top_inst (.ref_clk_i(clk), .resetn_i(rstn),
    .pin_resetn_i(pin_rstn), .wdg_reset_i(wdg_rst), .supply_low_i(sup_low),
    .wait_instr_i(wi), .halt_instr_i(hi), .watchdog_en_i(wdg_en), .irq_i(irq), .nmi_i(nmi),
    .port_irq_i(pirq), .port_irq_en_i(port_en), .opt_clk_src_i(o_src), .opt_gain_i(o_gain),
    .opt_trim_i(o_trim), .opt_lvl_i(o_lvl), .opt_wake_i(o_wake), .apb_req_i(req),
    .apb_rsp_o(rsp), .cpu_reset_o(cpu_rst), .cpu_clk_en_o(cen), .periph_clk_en_o(pen),
    .osc_on_o(osc), .clk_src_o(src), .gain_stages_o(gst), .osc_trim_o(trim),
    .supply_drop_level_o(lvl), .serve_irq_o(serve), .mode_o(mode));
  pmcc_cpu_model pmcc_cpu_model_inst (.ref_clk_i(clk), .resetn_i(rstn), .mode_i(mode),
    .serve_irq_i(serve), .do_wait_i(do_wait), .do_halt_i(do_halt), .do_irq_i(do_irq),
    .do_nmi_i(do_nmi), .do_port_i(do_port), .wait_instr_o(wi), .halt_instr_o(hi),
    .irq_o(irq), .nmi_o(nmi), .port_irq_o(pirq));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // one cpu request: wait, halt, irq, nmi, port from high bit to low
  task automatic ask(input logic [4:0] v);
    @(posedge clk);
    {do_wait, do_halt, do_irq, do_nmi, do_port} <= v;
    @(posedge clk);
    {do_wait, do_halt, do_irq, do_nmi, do_port} <= 5'h00;
  endtask : ask

  // apb transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'h1;
    do @(posedge clk); while (rsp.pready !== 1'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic wait_mode(input pmcc_mode_t m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_mode

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_startup;
    wait_mode(PMCC_PRESC, 100);
    check(src, 2'h0);
    check(n >= SCYC && n <= SCYC + 3, 1'h1);
    wait_mode(PMCC_RUN, 100);
    check(n >= 2 * SCYC - 1 && n <= 2 * SCYC + 3, 1'h1);
    cyc(2);
    check(src, 2'h1);
    check(cpu_rst, 1'h0);
  endtask : t_startup

  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, ra[i], 32'h0);
      check(rd, {24'h0, rv[i]});
      check(err, 1'h0);  // mapped read is accepted
    end
    apb(1'h1, 8'h08, 32'h3f);
    check(err, 1'h1);  // option bytes are read-only
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h14);
    apb(1'h0, 8'h10, 32'h0);
    check(err, 1'h1);  // unmapped place is refused
    apb(1'h0, 8'hb9, 32'h0);
    check(err, 1'h1);  // unaligned access is refused
    apb(1'h0, 8'hc0, 32'h0);
    check(rd, 32'h12);  // status: running, monitor on
  endtask : t_regs

  task automatic t_div;
    int p;
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, 8'hb8, {26'h0, dv[i]});
      apb(1'h0, 8'hb8, 32'h0);
      check(rd, {26'h0, dv[i]});
      repeat (2) begin
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (cen !== 1'h1 && n < 200);
      end
      p = 0;
      do begin
        @(posedge clk);
        p++;
        check(pen, 1'h1);
      end while (cen !== 1'h1 && p < 200);
      check(p, (i == 7) ? 64 : (1 << i));
    end
  endtask : t_div

  task automatic t_wait;
    ask(5'h10);
    wait_mode(PMCC_WAIT, 20);
    check(mode, PMCC_WAIT);
    repeat (70) begin
      @(posedge clk);
      check(cen, 1'h0);
      check(pen, 1'h1);
    end
    ask(5'h04);
    wait_mode(PMCC_RUN, 20);
    check(mode, PMCC_RUN);
  endtask : t_wait

  task automatic t_halt(input logic use_nmi);
    wdg_en <= 1'h1;
    ask(5'h08);
    cyc(10);
    check(mode, PMCC_RUN);
    wdg_en <= 1'h0;
    ask(5'h08);
    wait_mode(PMCC_HALT, 20);
    cyc(1);
    check(osc, 1'h0);
    check(pen, 1'h0);
    sup_low <= 1'h1;
    if (!use_nmi) ask(5'h01);
    cyc(300);
    check(mode, PMCC_HALT);
    sup_low <= 1'h0;
    if (use_nmi) ask(5'h02);
    else port_en <= 1'h1;
    wait_mode(PMCC_FIXED, 10);
    check(osc, 1'h1);
    wait_mode(PMCC_RUN, 200);
    check(n >= 3 * SCYC - 1 && n <= 3 * SCYC + 3, 1'h1);
    s = serve;
    @(posedge clk);
    check(s | serve, 1'h1);
    port_en <= 1'h0;
  endtask : t_halt

  task automatic t_drop;
    apb(1'h1, 8'hb8, 32'h4);
    sup_low <= 1'h1;
    cyc(200);
    sup_low <= 1'h0;
    cyc(300);
    check(mode, PMCC_RUN);
    sup_low <= 1'h1;
    wait_mode(PMCC_LVDRST, 400);
    check(n >= 249 && n <= 253, 1'h1);
    cyc(50);
    check(cpu_rst, 1'h1);
    sup_low <= 1'h0;
    wait_mode(PMCC_RUN, 400);
    check(n >= 249 && n <= 254, 1'h1);
    cyc(2);
    check(cpu_rst, 1'h0);
    apb(1'h0, 8'hb8, 32'h0);
    check(rd, 32'h0);
  endtask : t_drop

  task automatic t_wdg;
    apb(1'h1, 8'hb8, 32'h2);
    wdg_rst <= 1'h1;
    cyc(1);
    wdg_rst <= 1'h0;
    s = 1'h0;
    repeat (4) begin
      @(posedge clk);
      s = s | cpu_rst;
    end
    check(s, 1'h1);
    check(mode, PMCC_RUN);
    apb(1'h0, 8'hb8, 32'h0);
    check(rd, 32'h0);
  endtask : t_wdg

  task automatic t_opts;
    for (int i = 0; i < 8; i++) begin
      o_gain <= i[2:0];
      o_src <= i[1:0];
      o_lvl <= i[1:0];
      pin_rstn <= 1'h0;
      cyc(2);
      pin_rstn <= 1'h1;
      cyc(1);
      wait_mode(PMCC_RUN, 200);
      cyc(2);
      check(gst, gx[i]);
      check(src, i[1] ? 2'h2 : i[1:0]);
      check(lvl, i[1:0]);
      check(trim, 6'h14);
      apb(1'h0, 8'hc0, 32'h0);
      check(rd[4], i[1:0] != 2'h0);
      check(rd[5], i[2:0] inside {3'h2, 3'h4, 3'h6});
    end
  endtask : t_opts

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    t_startup();
    t_regs();
    t_div();
    t_wait();
    t_halt(1'h0);
    t_halt(1'h1);
    t_drop();
    t_wdg();
    t_opts();
    give_verdict();
  end
endmodule : pmcc_top_test
